// >>> verilog/atp_pkg.sv
`default_nettype none
package atp_pkg;
  // queue write addresses, they mark start, middle and end of a packet
  localparam logic [7:0] ADDR_FIRST     = 8'h80;
  localparam logic [7:0] ADDR_MID       = 8'h84;
  localparam logic [7:0] ADDR_FIRST_UPD = 8'h88;
  localparam logic [7:0] ADDR_LAST      = 8'h8c;

  // field positions in the control quadlet, counted from the lsb
  localparam int SPD_LSB    = 16;
  localparam int TLABEL_LSB = 10;
  localparam int RT_LSB     = 8;
  localparam int TCODE_LSB  = 4;
  localparam int PRI_LSB    = 0;
  // second and fourth quadlet
  localparam int DESTID_LSB = 16;
  localparam int RCODE_LSB  = 12;
  localparam int DLEN_LSB   = 16;

  localparam logic [1:0] SPD_S100  = 2'h0;
  localparam logic [1:0] SPD_S200  = 2'h1;
  localparam logic [1:0] SPD_S400  = 2'h2;
  localparam logic [1:0] SPD_UNDEF = 2'h3;

  localparam logic [1:0] RT_NEW    = 2'h0;
  localparam logic [1:0] RT_RETRYX = 2'h1;
  localparam logic [1:0] RT_RETRYA = 2'h2;
  localparam logic [1:0] RT_RETRYB = 2'h3;

  localparam logic [15:0] QUAD_BYTES = 16'h0004;
  localparam logic [1:0]  IDX_NODATA = 2'h2;
  localparam logic [1:0]  IDX_FULL   = 2'h3;

  typedef enum logic [1:0] {
    KIND_QUAD_NODATA = 2'b00,
    KIND_QUAD_DATA   = 2'b01,
    KIND_BLOCK       = 2'b10,
    KIND_BLOCK_WRESP = 2'b11
  } atp_kind_t;

  typedef struct packed {
    atp_kind_t   kind;
    logic [1:0]  spd;
    logic [5:0]  tLabel;
    logic [1:0]  rt;
    logic [3:0]  tCode;
    logic [3:0]  prioLevel;
    logic [9:0]  busNum;
    logic [5:0]  nodeNum;
    logic [15:0] offsetHigh;
    logic [31:0] offsetLow;
    logic        lockResp;
    logic [3:0]  respCode;
    logic [31:0] quadData;
    logic [15:0] dataLength;
    logic [15:0] extTcode;
    logic        isRequest;
  } atp_req_t;
endpackage
`default_nettype wire

// >>> verilog/atp_host_writer.sv
// Functional notes
// [R1] speed code placed; undefined code 11 refused
// [R2] outstanding request labels kept unique
// [R3] retry code copied into control quadlet
// [R4] transaction code copied from request
// [R5] cable mode forces priority bits zero
// [R6] destination id is bus and node
// [R7] misaligned destination offset refused
// [R8] data quadlet only for quadlet-with-data
// [R9] control quadlet, then two address quadlets
// [R10] fourth block quadlet upper half length
// [R11] fourth block quadlet lower half extended code
// [R12] zero length block sends no payload
// [R13] first payload byte in byte 0
// [R14] lock response code in offset top bits
// [R15] block write response built as quadlet
// [R16] write address marks start, middle, end
// [R17] control quadlet field positions fixed
// [R18] final partial payload quadlet zero padded
`timescale 1ns/100ps
`default_nettype none
module atp_host_writer #(
  parameter bit CABLE_MODE = 1'b1
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire atp_pkg::atp_req_t req,
  input  wire logic              reqValid,
  output logic                   reqReady,
  output logic                   reqError,
  input  wire logic              payValid,
  input  wire logic [31:0]       payData,
  output logic                   payReady,
  input  wire logic              labelFree,
  input  wire logic [5:0]        labelFreeId,
  output logic                   qWr,
  output logic [7:0]             qAddr,
  output logic [31:0]            qData,
  input  wire logic              qReady,
  output logic                   busy
);
  import atp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_PAY  = 2'b10
  } atp_state_t;

  atp_state_t  state_q;
  logic [31:0] hdr_q [4];
  logic [1:0]  idx_q;
  logic [1:0]  lastIdx_q;
  logic        hasPay_q;
  logic [15:0] rem_q;
  logic [63:0] labelBusy_q;
  logic        qWr_q;
  logic [7:0]  qAddr_q;
  logic [31:0] qData_q;
  logic        reqError_q;

  logic        accept;
  logic        bad;
  logic        refuse;
  logic        good;
  logic        slotFree;
  logic        emit;
  logic [7:0]  emitAddr;
  logic [31:0] emitData;
  logic        lastPay;
  logic [31:0] padMask;
  logic [31:0] q0;
  logic [31:0] q1;
  logic [31:0] q3;
  logic        blockLike;
  logic        noData;
  logic [5:0]  reqLabel;
  logic [15:0] reqLen;

  assign reqLabel  = req.tLabel;
  assign reqLen    = req.dataLength;
  assign reqReady  = (state_q == ST_IDLE);
  assign accept    = reqValid && reqReady;
  assign bad       = (req.spd == SPD_UNDEF) //R1
                     || (req.offsetLow[1:0] != 2'h0) //R7
                     || (req.isRequest && labelBusy_q[req.tLabel]); //R2
  assign good      = accept && !bad;
  assign refuse    = accept && bad;
  assign blockLike = (req.kind == KIND_BLOCK);
  // block write response carries no length quadlet
  assign noData    = (req.kind == KIND_QUAD_NODATA)
                     || (req.kind == KIND_BLOCK_WRESP); //R15 R8

  always_comb begin
    q0 = '0;
    q0[SPD_LSB+:2]    = req.spd; //R1 R17
    q0[TLABEL_LSB+:6] = req.tLabel; //R17
    q0[RT_LSB+:2]     = req.rt; //R3 R17
    q0[TCODE_LSB+:4]  = req.tCode; //R4 R17
    // cable nodes must see zero priority whatever the caller asked
    q0[PRI_LSB+:4]    = CABLE_MODE ? 4'h0 : req.prioLevel; //R5 R17
    q1 = '0;
    q1[DESTID_LSB+:16] = {req.busNum, req.nodeNum}; //R6
    if (req.lockResp) begin
      q1[RCODE_LSB+:4] = req.respCode; //R14
    end else begin
      q1[15:0] = req.offsetHigh;
    end
    if (req.kind == KIND_QUAD_DATA) begin
      q3 = req.quadData; //R8
    end else begin
      q3 = '0;
      q3[DLEN_LSB+:16] = req.dataLength; //R10
      q3[15:0]         = req.extTcode; //R11
    end
  end

  assign slotFree = !qWr_q || qReady;
  assign payReady = (state_q == ST_PAY) && slotFree;
  assign lastPay  = (rem_q <= QUAD_BYTES);

  always_comb begin
    case (rem_q[1:0])
      2'h1:    padMask = 32'hff000000;
      2'h2:    padMask = 32'hffff0000;
      2'h3:    padMask = 32'hffffff00;
      default: padMask = 32'hffffffff;
    endcase
    if (!lastPay) begin
      padMask = 32'hffffffff;
    end
  end

  always_comb begin
    emit     = 1'b0;
    emitAddr = ADDR_MID;
    emitData = '0;
    case (state_q)
      ST_HDR: begin
        emit     = slotFree;
        emitData = hdr_q[idx_q];
        if (idx_q == 2'h0) begin
          emitAddr = ADDR_FIRST; //R16 R9
        end else if (idx_q == lastIdx_q && !hasPay_q) begin
          emitAddr = ADDR_LAST; //R16
        end
      end
      ST_PAY: begin
        emit     = payValid && slotFree;
        emitData = payData & padMask; //R13 R18
        if (lastPay) begin
          emitAddr = ADDR_LAST; //R16
        end
      end
      default: begin
        emit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_IDLE;
      idx_q     <= 2'h0;
      lastIdx_q <= 2'h0;
      hasPay_q  <= 1'b0;
      rem_q     <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (good) begin
            state_q   <= ST_HDR;
            idx_q     <= 2'h0;
            lastIdx_q <= noData ? IDX_NODATA : IDX_FULL; //R8
            // zero length means the header ends the packet
            hasPay_q  <= blockLike && (req.dataLength != 16'h0000); //R12
            rem_q     <= req.dataLength; //R10
          end
        end
        ST_HDR: begin
          if (emit) begin
            if (idx_q == lastIdx_q) begin
              state_q <= hasPay_q ? ST_PAY : ST_IDLE;
            end else begin
              idx_q <= idx_q + 2'h1;
            end
          end
        end
        ST_PAY: begin
          if (emit) begin
            if (lastPay) begin
              state_q <= ST_IDLE;
              rem_q   <= 16'h0000;
            end else begin
              rem_q <= rem_q - QUAD_BYTES;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // header words captured at accept so req may change afterwards
  always_ff @(posedge clock) begin
    if (good) begin
      hdr_q[0] <= q0;
      hdr_q[1] <= q1; //R9
      hdr_q[2] <= req.offsetLow; //R9
      hdr_q[3] <= q3;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      qWr_q   <= 1'b0;
      qAddr_q <= 8'h00;
      qData_q <= 32'h00000000;
    end else if (emit) begin
      qWr_q   <= 1'b1;
      qAddr_q <= emitAddr;
      qData_q <= emitData;
    end else if (qReady) begin
      qWr_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reqError_q <= 1'b0;
    end else begin
      reqError_q <= refuse; //R1 R7 R2
    end
  end

  // label set beats a release of the same label in one cycle
  for (genvar i = 0; i < 64; i++) begin : g_label
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        labelBusy_q[i] <= 1'b0;
      end else if (good && req.isRequest && req.tLabel == 6'(i)) begin
        labelBusy_q[i] <= 1'b1; //R2
      end else if (labelFree && labelFreeId == 6'(i)) begin
        labelBusy_q[i] <= 1'b0;
      end
    end
  end

  assign qWr      = qWr_q;
  assign qAddr    = qAddr_q;
  assign qData    = qData_q;
  assign reqError = reqError_q;
  assign busy     = (state_q != ST_IDLE) || qWr_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_spd_defined: assert property ( //R1
    qWr_q && qAddr_q == ADDR_FIRST |-> qData_q[SPD_LSB+:2] != SPD_UNDEF)
    else $error("undefined speed code sent");
  chk_spd_refused: assert property ( //R1
    accept && req.spd == SPD_UNDEF |=> reqError_q && state_q == ST_IDLE)
    else $error("undefined speed not refused");
  chk_prio_cable: assert property ( //R5
    CABLE_MODE && qWr_q && qAddr_q == ADDR_FIRST |-> qData_q[3:0] == 4'h0)
    else $error("nonzero priority in cable mode");
  chk_label_held: assert property ( //R2
    good && req.isRequest |=> labelBusy_q[$past(reqLabel)])
    else $error("label not marked outstanding");
  chk_align_refused: assert property ( //R7
    accept && req.offsetLow[1:0] != 2'h0
    |=> reqError_q ##1 (reqError_q == $past(refuse)))
    else $error("misaligned offset not refused");
  chk_len_loaded: assert property ( //R10
    good && blockLike |=> rem_q == $past(reqLen))
    else $error("data length not taken");
  chk_zero_len: assert property ( //R12
    good && blockLike && req.dataLength == 16'h0000
    |=> (state_q != ST_PAY)[*4])
    else $error("payload phase after zero length");
  chk_nodata_end: assert property ( //R8
    state_q == ST_HDR && emit && idx_q == IDX_NODATA && lastIdx_q == IDX_NODATA
    |=> qWr_q && qAddr_q == ADDR_LAST && state_q == ST_IDLE)
    else $error("no-data packet did not end on third quadlet");
  chk_pay_end: assert property ( //R16
    state_q == ST_PAY && emit && lastPay
    |=> qAddr_q == ADDR_LAST && state_q == ST_IDLE)
    else $error("last payload not written to end address");
  chk_pad_zero: assert property ( //R18
    state_q == ST_PAY && emit && rem_q == 16'h0001 |=> qData_q[23:0] == 24'h0)
    else $error("final quadlet not padded");
  chk_byte_order: assert property ( //R13
    state_q == ST_PAY && emit && !lastPay |=> qData_q == $past(payData))
    else $error("payload quadlet altered");
  chk_stall_hold: assert property ( //R16
    qWr_q && !qReady |=> qWr_q && $stable(qAddr_q) && $stable(qData_q))
    else $error("write changed while stalled");

  cov_block_pay: cover property (state_q == ST_PAY && emit && lastPay);
  cov_quad_data: cover property (good && req.kind == KIND_QUAD_DATA);
  cov_refused:   cover property (reqError_q);
  cov_stall:     cover property (qWr_q && !qReady ##1 qWr_q && qReady);
endmodule
`default_nettype wire

// >>> sim/atp_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module atp_dev_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        qWr,
  input  wire logic [7:0]  qAddr,
  input  wire logic [31:0] qData,
  output logic             qReady
);
  import atp_pkg::*;
  logic [39:0] log[$];
  // slow mode stalls every other cycle, so writes must hold while waiting
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) qReady <= 1'b1;
    else qReady <= slow ? ~qReady : 1'b1;
  end
  // packet bounds come from the address; fields judged by the bench
  always @(posedge clock) begin
    if (resetn && qWr && qReady) log.push_back({qAddr, qData});
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  import atp_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  atp_req_t    req = '0;
  atp_req_t    b = '0;
  logic        reqValid = 1'b0;
  logic        payValid = 1'b0;
  logic        labelFree = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] payData = '0;
  logic [5:0]  labelFreeId = '0;
  logic        reqReady, reqError, payReady, qWr, qReady, busy, err, rdy;
  logic [7:0]  qAddr;
  logic [31:0] qData;
  logic [31:0] expq[$];
  logic [31:0] pay[$];
  int          failures = 0;
  int          check_count = 0;
  atp_host_writer #(.CABLE_MODE(1'b1)) i_atp_host_writer (.clock(clock),
    .resetn(resetn), .req(req), .reqValid(reqValid), .reqReady(reqReady),
    .reqError(reqError), .payValid(payValid), .payData(payData),
    .payReady(payReady), .labelFree(labelFree), .labelFreeId(labelFreeId),
    .qWr(qWr), .qAddr(qAddr), .qData(qData), .qReady(qReady), .busy(busy));
  atp_dev_model i_atp_dev_model (.clock(clock), .resetn(resetn), .slow(slow),
    .qWr(qWr), .qAddr(qAddr), .qData(qData), .qReady(qReady));
  always #50 clock = ~clock;
  task conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // error pulse may land one cycle late, so two samples are merged
  task automatic send(input atp_req_t r);
    int n;
    @(negedge clock);
    req = r;
    reqValid = 1'b1;
    @(negedge clock);
    reqValid = 1'b0;
    err = reqError;
    rdy = reqReady;
    @(negedge clock);
    err = err | reqError;
    while (pay.size() > 0) begin
      payValid = 1'b1;
      payData = pay[0];
      n = 0;
      while (payReady !== 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
      end
      @(negedge clock);
      void'(pay.pop_front());
    end
    payValid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic chk_pkt;
    logic [7:0] a;
    `CHK("count", expq.size(), i_atp_dev_model.log.size())
    foreach (expq[i]) begin
      a = i == 0 ? ADDR_FIRST : i == expq.size() - 1 ? ADDR_LAST : ADDR_MID;
      `CHK("addr", a, i_atp_dev_model.log[i][39:32])
      `CHK("quad", expq[i], i_atp_dev_model.log[i][31:0])
    end
    expq.delete();
    i_atp_dev_model.log.delete();
  endtask
  task automatic hdr(input atp_req_t r);
    expq.push_back({14'h0, r.spd, r.tLabel, r.rt, r.tCode, 4'h0});
    expq.push_back({r.busNum, r.nodeNum,
      r.lockResp ? {r.respCode, 12'h000} : r.offsetHigh});
    expq.push_back(r.offsetLow);
  endtask
  task automatic t_quad;
    atp_req_t r;
    r = b;
    for (int i = 0; i < 4; i++) begin
      r.spd = 2'(i % 3);
      r.rt = 2'(i);
      r.prioLevel = 4'ha;
      r.kind = i[0] ? KIND_QUAD_DATA : KIND_QUAD_NODATA;
      slow = (i == 1);
      send(r);
      `CHK("err", 1'b0, err)
      `CHK("ready", 1'b0, rdy)
      hdr(r);
      if (i[0]) expq.push_back(r.quadData);
      chk_pkt();
    end
    slow = 1'b0;
  endtask
  task automatic t_refuse;
    atp_req_t r;
    r = b;
    r.spd = SPD_UNDEF;
    send(r);
    `CHK("err", 1'b1, err)
    `CHK("ready", 1'b1, rdy)
    r = b;
    r.offsetLow = 32'hf0000402;
    send(r);
    `CHK("err", 1'b1, err)
    chk_pkt();
    r = b;
    r.isRequest = 1'b1;
    r.tLabel = 6'h05;
    send(r);
    hdr(r);
    chk_pkt();
    send(r);
    `CHK("err", 1'b1, err)
    @(negedge clock);
    labelFree = 1'b1;
    labelFreeId = 6'h05;
    @(negedge clock);
    labelFree = 1'b0;
    send(r);
    `CHK("err", 1'b0, err)
    hdr(r);
    chk_pkt();
  endtask
  task automatic t_block;
    atp_req_t r;
    r = b;
    r.kind = KIND_BLOCK;
    r.dataLength = 16'h0005;
    r.extTcode = 16'h0002;
    pay = {32'h11223344, 32'h55667788};
    send(r);
    hdr(r);
    expq.push_back({16'h0005, 16'h0002});
    expq.push_back(32'h11223344);
    expq.push_back(32'h55000000);
    chk_pkt();
    r.dataLength = 16'h0000;
    send(r);
    hdr(r);
    expq.push_back({16'h0000, 16'h0002});
    chk_pkt();
    r.lockResp = 1'b1;
    r.respCode = 4'h6;
    r.dataLength = 16'h0004;
    pay = {32'ha5a5a5a5};
    slow = 1'b1;
    send(r);
    hdr(r);
    expq.push_back({16'h0004, 16'h0002});
    expq.push_back(32'ha5a5a5a5);
    chk_pkt();
    slow = 1'b0;
    r.kind = KIND_BLOCK_WRESP;
    r.lockResp = 1'b0;
    send(r);
    hdr(r);
    chk_pkt();
  endtask
  // whole run is about a hundred cycles; limit leaves ample margin
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    conclude();
  end
  initial begin
    b.busNum = 10'h3ff;
    b.nodeNum = 6'h2a;
    b.offsetHigh = 16'hffff;
    b.offsetLow = 32'hf0000400;
    b.tCode = 4'h4;
    b.tLabel = 6'h09;
    b.quadData = 32'hdeadbeef;
    repeat (12) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_quad();
    t_refuse();
    t_block();
    conclude();
  end
endmodule
`default_nettype wire
